// File: hs_phy_params.svh
// Constants for the transceiver clock-qualification and line-state block.
// Assumes a 100 MHz ref_clk; the oscillator arrives as an unrelated pin.
`ifndef HS_PHY_PARAMS_SVH
`define HS_PHY_PARAMS_SVH

// Clock rate and timing figures in their own units
`define REF_CLK_MHZ 100
`define USABLE_MAX_US 5600
`define NOMINAL_MAX_US 20000
`define OSC_NOM_PERIOD 5'h10
`define OSC_USABLE_MIN 5'h0F
`define OSC_USABLE_MAX 5'h11
`define USABLE_GOOD_PERIODS 8'h08
`define NOMINAL_GOOD_PERIODS 16'h0400

// Register byte offsets
`define REG_CTRL 8'h00
`define REG_STATUS 8'h04
`define REG_GOODCNT 8'h08

// Field positions
`define CTRL_SWSUSP 0
`define ST_LINE_LO 0
`define ST_USABLE 2
`define ST_NOMINAL 3
`define ST_USABLE_LATE 4
`define ST_NOMINAL_LATE 5

// Reset value and the htrans bit that marks an active transfer
`define CTRL_RESET 1'b0
`define HTRANS_NONSEQ_BIT 1

`endif

// File: hs_phy_pkg.sv
// Types shared by the transceiver block.
// Constants live in hs_phy_params.svh.
package hs_phy_pkg;
    typedef struct packed {
        logic [7:0] addr;
        logic write;
        logic valid;
    } bus_req_s;

    typedef struct packed {
        logic nominalLate;
        logic usableLate;
        logic nominal;
        logic usable;
        logic [1:0] lineState;
    } phy_status_s;

    typedef enum logic [1:0] {SLEEP, QUALIFY, USABLE, NOMINAL} clk_state_e;
endpackage

// File: sync2.sv
// Two-flop synchroniser for a vector of unrelated pins.
// Assumes each bit is an independent level; no bus coherence is promised.
module sync2 #(
    parameter int W = 1
) (
    input wire logic ref_clk,
    input wire logic resetn,
    input wire logic clkEn,
    input wire logic [W-1:0] din,
    output logic [W-1:0] dout
);
    logic [W-1:0] stage1;

    // First stage feeds only the second
    always_ff @(posedge ref_clk)
    begin
        if (!resetn)
        begin
            stage1 <= '0;
            dout <= '0;
        end
        else if (clkEn)
        begin
            stage1 <= din;
            dout <= stage1;
        end
    end
endmodule

// File: hs_phy_clkqual.sv
// Transceiver-side clock qualification and raw line-state report.
// Assumes an AHB-Lite master on ref_clk, oscillator and line pins asynchronous.
//
// Overview of operation
// - Transceiver reports line state raw, with no filter or debounce.
// - After suspend, output clock stays silent until within 10% and duty; the code checks only the period (15 to 17 ref_clk cycles), not duty.
// - First usable output clock edge comes before 5.6ms after wake.
// - Output clock reaches 500 ppm accuracy by 20.0ms after wake.
//
// Added by the designer: the AHB-Lite interface to the registers and the register offsets.

// Macros must exist before the parameter defaults below use them
`include "hs_phy_params.svh"

module hs_phy_clkqual
    import hs_phy_pkg::*;
#(
    parameter logic [21:0] USABLE_LIMIT = 22'(`USABLE_MAX_US * `REF_CLK_MHZ),
    parameter logic [21:0] NOMINAL_LIMIT = 22'(`NOMINAL_MAX_US * `REF_CLK_MHZ),
    parameter logic [15:0] NOMINAL_PERIODS = `NOMINAL_GOOD_PERIODS
) (
    input wire logic ref_clk,
    input wire logic resetn,
    input wire logic clkEn,
    // AHB-Lite slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    // Pins
    input wire logic suspendN,
    input wire logic oscRaw,
    input wire logic [1:0] linePins,
    output logic [1:0] lineState,
    output logic clkOut,
    output logic clkUsable
);
    logic [1:0] lineSync;
    logic [1:0] wakeOscSync;
    logic oscPrev;
    logic oscRise;
    logic awake;
    logic swSuspend;
    bus_req_s req;
    phy_status_s status;
    logic usableLate;
    logic nominalLate;
    clk_state_e clkState;
    logic [21:0] wakeTimer;
    logic [4:0] periodCnt;
    logic [7:0] goodCnt;
    logic [15:0] nominalCnt;
    logic periodOk;
    logic periodExact;

    // Pins pass two flops before any logic reads them
    sync2 #(.W(2)) u_line_sync (
        .ref_clk(ref_clk),
        .resetn(resetn),
        .clkEn(clkEn),
        .din(linePins),
        .dout(lineSync)
    );
    sync2 #(.W(2)) u_wake_sync (
        .ref_clk(ref_clk),
        .resetn(resetn),
        .clkEn(clkEn),
        .din({suspendN, oscRaw}),
        .dout(wakeOscSync)
    );

    assign awake = wakeOscSync[1] && !swSuspend;
    assign oscRise = wakeOscSync[0] && !oscPrev;

    // Window check on a measured oscillator period
    function automatic logic in_window(input logic [4:0] p, input logic [4:0] lo,
                                       input logic [4:0] hi);
        in_window = (p >= lo) && (p <= hi);
    endfunction

    assign periodOk = in_window(periodCnt, `OSC_USABLE_MIN, `OSC_USABLE_MAX);
    assign periodExact = in_window(periodCnt, `OSC_NOM_PERIOD, `OSC_NOM_PERIOD);

    // Line state forwarded sample for sample; persistence is the link's job
    always_ff @(posedge ref_clk)
    begin
        if (!resetn)
            lineState <= 2'h0;
        else if (clkEn)
            lineState <= lineSync;
    end

    // Oscillator edge finder and period measurement
    always_ff @(posedge ref_clk)
    begin
        if (!resetn)
        begin
            oscPrev <= 1'b0;
            periodCnt <= 5'h00;
        end
        else if (clkEn)
        begin
            oscPrev <= wakeOscSync[0];
            if (oscRise || !awake)
                periodCnt <= 5'h01;
            else if (periodCnt != 5'h1F)
                periodCnt <= periodCnt + 5'h01; // Saturates on a stopped oscillator
        end
    end

    // Time since wake, saturating; measures both deadlines
    always_ff @(posedge ref_clk)
    begin
        if (!resetn)
            wakeTimer <= 22'h000000;
        else if (clkEn)
        begin
            if (!awake)
                wakeTimer <= 22'h000000;
            else if (wakeTimer != 22'h3FFFFF)
                wakeTimer <= wakeTimer + 22'h000001;
        end
    end

    // Qualification state: sleep, qualify, usable, nominal
    always_ff @(posedge ref_clk)
    begin
        if (!resetn)
        begin
            clkState <= SLEEP;
            goodCnt <= 8'h00;
            nominalCnt <= 16'h0000;
        end
        else if (clkEn)
        begin
            if (!awake)
            begin
                clkState <= SLEEP;
                goodCnt <= 8'h00;
                nominalCnt <= 16'h0000;
            end
            else
            begin
                unique case (clkState)
                    SLEEP:
                        clkState <= QUALIFY;
                    QUALIFY:
                        if (oscRise)
                        begin
                            // Any bad period restarts the count: edges stay hidden
                            if (!periodOk)
                                goodCnt <= 8'h00;
                            else if (goodCnt + 8'h01 >= `USABLE_GOOD_PERIODS)
                                clkState <= USABLE;
                            else
                                goodCnt <= goodCnt + 8'h01;
                        end
                    USABLE:
                        if (oscRise)
                        begin
                            if (!periodExact)
                                nominalCnt <= 16'h0000;
                            else if (nominalCnt + 16'h0001 >= NOMINAL_PERIODS)
                                clkState <= NOMINAL;
                            else
                                nominalCnt <= nominalCnt + 16'h0001;
                        end
                    NOMINAL:
                        clkState <= NOMINAL;
                endcase
            end
        end
    end

    assign clkUsable = (clkState == USABLE) || (clkState == NOMINAL);

    // Gated output clock; silent until qualified so no runt edge escapes
    always_ff @(posedge ref_clk)
    begin
        if (!resetn)
            clkOut <= 1'b0;
        else if (clkEn)
            clkOut <= clkUsable && wakeOscSync[0];
    end

    // Late flags: sticky, cleared by writing one, a new set wins
    logic clrUsableLate;
    logic clrNominalLate;
    logic usableLateEvt;
    logic nominalLateEvt;
    assign usableLateEvt = awake && !clkUsable && (wakeTimer >= USABLE_LIMIT);
    assign nominalLateEvt = awake && (clkState != NOMINAL)
        && (wakeTimer >= NOMINAL_LIMIT);

    always_ff @(posedge ref_clk)
    begin
        if (!resetn)
        begin
            usableLate <= 1'b0;
            nominalLate <= 1'b0;
        end
        else if (clkEn)
        begin
            if (usableLateEvt)
                usableLate <= 1'b1;
            else if (clrUsableLate)
                usableLate <= 1'b0;
            if (nominalLateEvt)
                nominalLate <= 1'b1;
            else if (clrNominalLate)
                nominalLate <= 1'b0;
        end
    end

    // Status word built in one process so no field has two drivers
    always_comb
    begin
        status.nominalLate = nominalLate;
        status.usableLate = usableLate;
        status.lineState = lineState;
        status.usable = clkUsable;
        status.nominal = (clkState == NOMINAL);
    end

    // AHB-Lite: zero wait states, always OKAY
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;

    // Address phase capture
    always_ff @(posedge ref_clk)
    begin
        if (!resetn)
            req <= '0;
        else if (clkEn && hready)
        begin
            req.valid <= hsel && htrans[`HTRANS_NONSEQ_BIT];
            req.write <= hwrite;
            req.addr <= haddr[7:0];
        end
    end

    assign clrUsableLate = clkEn && req.valid && req.write
        && (req.addr == `REG_STATUS) && hwdata[`ST_USABLE_LATE];
    assign clrNominalLate = clkEn && req.valid && req.write
        && (req.addr == `REG_STATUS) && hwdata[`ST_NOMINAL_LATE];

    // Control register: software can hold the transceiver asleep
    always_ff @(posedge ref_clk)
    begin
        if (!resetn)
            swSuspend <= `CTRL_RESET;
        else if (clkEn && req.valid && req.write && (req.addr == `REG_CTRL))
            swSuspend <= hwdata[`CTRL_SWSUSP];
    end

    // Read data registered at the address phase, valid in the data phase
    always_ff @(posedge ref_clk)
    begin
        if (!resetn)
            hrdata <= 32'h00000000;
        else if (clkEn && hready)
        begin
            hrdata <= 32'h00000000;
            if (hsel && htrans[`HTRANS_NONSEQ_BIT] && !hwrite)
            begin
                unique case (haddr[7:0])
                    `REG_CTRL:
                        hrdata[`CTRL_SWSUSP] <= swSuspend;
                    `REG_STATUS:
                        hrdata[5:0] <= status;
                    `REG_GOODCNT:
                        hrdata[15:0] <= nominalCnt;
                    default:
                        hrdata <= 32'h00000000; // Unmapped reads zero
                endcase
            end
        end
    end

    // Checks
    a_line_raw: assert property (@(posedge ref_clk) disable iff (!resetn)
        clkEn |=> lineState == $past(lineSync))
        else $error("line state not passed through unfiltered");
    a_clk_silent: assert property (@(posedge ref_clk) disable iff (!resetn)
        (clkEn && !clkUsable) |=> !clkOut)
        else $error("output clock toggled before qualification");
    a_usable_good: assert property (@(posedge ref_clk) disable iff (!resetn)
        $rose(clkUsable) |-> $past(goodCnt) + 8'h01 >= `USABLE_GOOD_PERIODS
        && $past(periodOk))
        else $error("clock qualified without enough good periods");
    a_usable_late: assert property (@(posedge ref_clk) disable iff (!resetn)
        (clkEn && usableLateEvt) |=> status.usableLate)
        else $error("late usable clock not flagged");
    a_nominal_late: assert property (@(posedge ref_clk) disable iff (!resetn)
        (clkEn && nominalLateEvt) |=> status.nominalLate)
        else $error("late nominal clock not flagged");
    a_sleep_gate: assert property (@(posedge ref_clk) disable iff (!resetn)
        (clkEn && !awake) |=> (clkState == SLEEP) ##1 !clkOut)
        else $error("clock still running while asleep");

    c_usable: cover property (@(posedge ref_clk) disable iff (!resetn) $rose(clkUsable));
    c_nominal: cover property (@(posedge ref_clk) disable iff (!resetn)
        $rose(clkState == NOMINAL));
    c_late: cover property (@(posedge ref_clk) disable iff (!resetn) $rose(status.usableLate));
endmodule

// File: osc_far_model.sv
// Far-side models: oscillator pin, and a link that runs the chirp handshake.
// Assumes the bench holds run low while suspendN is low.
module osc_far_model (
    input wire logic run,
    input wire logic [7:0] halfNs,
    output logic oscRaw
);
    timeunit 1ns;
    timeprecision 100ps;

    // Offset of 2.5 ns keeps toggles away from ref_clk edges
    initial
    begin
        oscRaw = 1'b0;
        #2.5;
        forever
        begin
            if (run)
                #(halfNs) oscRaw = ~oscRaw;
            else
                #10 oscRaw = 1'b0; // Powered down: stands low
        end
    end
endmodule

// Link-side chirp handshake model timed by the transceiver's output clock.
module chirp_link_model #(
    parameter int PERSIST = 165,
    parameter int CHIRPS_NEEDED = 6,
    parameter logic [1:0] LINE_K = 2'h1,
    parameter logic [1:0] LINE_J = 2'h2
) (
    input wire logic clkOut,
    input wire logic clkUsable,
    input wire logic [1:0] lineState,
    input wire logic [31:0] holdCycles,
    input wire logic [31:0] deadline,
    output logic [1:0] opMode,
    output logic xcvrHs,
    output logic termHs
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [31:0] holdCnt;
    logic [31:0] waitCnt;
    int steady;
    int chirps;
    logic [1:0] lastLine;
    logic [1:0] expLine;

    // Chirp K and chirp J alternate, starting with K
    assign expLine = (chirps % 2 == 0) ? LINE_K : LINE_J;

    // Output clock only; cleared while it is unusable
    always @(posedge clkOut or negedge clkUsable)
    begin
        if (!clkUsable)
        begin
            holdCnt <= 32'h00000000;
            waitCnt <= 32'h00000000;
            steady <= 0;
            chirps <= 0;
            lastLine <= 2'h0;
            opMode <= 2'h0;
            xcvrHs <= 1'b0;
            termHs <= 1'b0;
        end
        else if (holdCnt < holdCycles)
        begin
            // Own chirp K from zeros, length counted in output clocks
            // Starts at once and ends early enough
            holdCnt <= holdCnt + 32'h00000001;
            opMode <= 2'h2; // No stuffing, no NRZI
            xcvrHs <= 1'b1;
        end
        else if (!termHs)
        begin
            // Listening opens as the own chirp ends
            opMode <= 2'h0;
            lastLine <= lineState;
            steady <= (lineState == lastLine) ? steady + 1 : 1; // A steady line steps it; a change restarts it at 1
            waitCnt <= waitCnt + 32'h00000001;
            if (waitCnt >= deadline)
                xcvrHs <= 1'b0; // No chirps in time: back to full speed
            if (lineState == lastLine && steady + 1 == PERSIST)
            begin
                // A filtered state must alternate, else the count restarts
                if (lineState != expLine)
                    chirps <= (lineState == LINE_K) ? 1 : 0;
                else if (chirps + 1 == CHIRPS_NEEDED)
                    termHs <= 1'b1; // Full sequence counted
                else
                    chirps <= chirps + 1;
            end
        end
    end
endmodule

// File: hs_phy_clkqual_tb.sv
// Self-checking bench for the clock qualifier and line-state report.
// Assumes a zero-wait AHB-Lite slave and shortened qualification limits.
`include "hs_phy_params.svh"
module hs_phy_clkqual_tb;
    timeunit 1ns;
    timeprecision 100ps;
    logic ref_clk = 1'b0;
    logic resetn = 1'b0;
    logic hwrite = 1'b0;
    logic [1:0] htrans = 2'h0;
    logic [31:0] haddr = 32'h0;
    logic [31:0] hwdata = 32'h0;
    logic suspendN = 1'b0;
    logic clkEn = 1'b1;
    logic [1:0] opMode;
    logic xcvrHs, termHs;
    // Own chirp and deadline shortened to keep the run short
    logic [31:0] chirpHold = 32'h00000064;
    logic [31:0] chirpDeadline = 32'h00000FA0;
    logic oscRun = 1'b0;
    logic [7:0] halfNs = 8'h64;
    logic [1:0] linePins = 2'h0;
    logic rdPhase = 1'b0;
    logic hreadyout, hresp, oscRaw, clkOut, clkUsable;
    logic [31:0] hrdata;
    logic [1:0] lineState;
    logic [31:0] expQ[$];
    logic [31:0] mskQ[$];
    int fails = 0;
    int compares = 0;

    always #5 ref_clk = ~ref_clk;

    hs_phy_clkqual #(.USABLE_LIMIT(22'h0007D0), .NOMINAL_LIMIT(22'h001770),
        .NOMINAL_PERIODS(16'h0010)) hs_phy_clkqual_i (
        .ref_clk(ref_clk), .resetn(resetn), .clkEn(clkEn), .hsel(1'b1),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2),
        .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp),
        .hrdata(hrdata), .suspendN(suspendN), .oscRaw(oscRaw), .linePins(linePins),
        .lineState(lineState), .clkOut(clkOut), .clkUsable(clkUsable));

    osc_far_model osc_far_model_i (.run(oscRun), .halfNs(halfNs), .oscRaw(oscRaw));

    chirp_link_model chirp_link_model_i (.clkOut(clkOut), .clkUsable(clkUsable),
        .lineState(lineState), .holdCycles(chirpHold), .deadline(chirpDeadline),
        .opMode(opMode), .xcvrHs(xcvrHs), .termHs(termHs));

    task automatic report_and_stop;
        $display("compares=%0d fails=%0d", compares, fails);
        if (fails == 0 && compares > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp)
        begin
            fails++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge ref_clk);
    endtask

    task automatic give_up;
        fails++;
        report_and_stop();
    endtask

    // Bounded wait for hready; a hang ends the run
    task automatic wait_rdy;
        int k;
        k = 0;
        @(posedge ref_clk);
        while (hreadyout !== 1'b1)
        begin
            k++;
            if (k > 50)
                give_up();
            @(posedge ref_clk);
        end
    endtask

    // One single transfer; a read notes its expected data and mask
    task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d,
                       input logic [31:0] m);
        haddr <= {24'h0, a};
        hwrite <= wr;
        htrans <= 2'h2;
        wait_rdy();
        htrans <= 2'h0;
        hwdata <= wr ? d : 32'h0;
        rdPhase <= ~wr;
        if (!wr)
        begin
            expQ.push_back(d);
            mskQ.push_back(m);
        end
        wait_rdy();
        rdPhase <= 1'b0;
    endtask

    // Counts cycles with clkOut high over a window
    task automatic cnt(input int n, input int exp);
        int ones;
        ones = 0;
        repeat (n)
        begin
            @(posedge ref_clk);
            ones += int'(clkOut !== 1'b0);
        end
        chk(32'(ones), 32'(exp));
    endtask

    // Read data checked against the oldest note at the data-phase edge
    always @(posedge ref_clk)
    begin
        if (rdPhase && hreadyout === 1'b1)
        begin
            chk(hrdata & mskQ[0], expQ[0] & mskQ[0]);
            chk({31'h0, hresp}, 32'h0);
            void'(expQ.pop_front());
            void'(mskQ.pop_front());
        end
    end

    // Main sequence
    initial
    begin
        int k;
        logic [1:0] v;
        void'($urandom(682));
        cyc(4);
        #1 chk({hrdata[29:0], lineState}, 32'h0);
        chk({30'h0, clkOut, clkUsable}, 32'h0);
        cyc(1);
        resetn <= 1'b1;
        bus(1'b0, `REG_CTRL, 32'h0, 32'hFFFFFFFF);
        bus(1'b0, `REG_GOODCNT, 32'h0, 32'hFFFFFFFF);
        bus(1'b1, 8'h0C, 32'hFFFFFFFF, 32'h0);
        bus(1'b0, 8'h0C, 32'h0, 32'hFFFFFFFF);
        // One-cycle pulses must pass straight through
        for (k = 0; k < 8; k++)
        begin
            v = 2'($urandom());
            linePins <= v;
            cyc(1);
            linePins <= 2'h0;
            cyc(2);
            #1 chk({30'h0, lineState}, {30'h0, v});
            cyc(1);
            #1 chk({30'h0, lineState}, 32'h0);
            cyc(1);
        end
        linePins <= 2'h3;
        cyc(4);
        bus(1'b0, `REG_STATUS, 32'h3, 32'h3);
        // Wake with an out-of-range oscillator: clock must stay gated
        suspendN <= 1'b1; // Link wakes the transceiver in one step
        oscRun <= 1'b1;
        cnt(2100, 0);
        chk({31'h0, clkUsable}, 32'h0);
        bus(1'b0, `REG_STATUS, 32'h10, 32'h14);
        halfNs <= 8'h50;
        k = 0;
        while (clkUsable !== 1'b1)
        begin
            k++;
            if (k > 600)
                give_up();
            cyc(1);
        end
        cnt(64, 32);
        cyc(400);
        bus(1'b0, `REG_STATUS, 32'h0C, 32'h0C);
        // Clock enable low freezes the gated clock and the line report
        v = 2'($urandom()) & 2'h2;
        clkEn <= 1'b0;
        linePins <= v;
        cyc(1);
        k = int'(clkOut);
        cnt(40, k * 40);
        chk({30'h0, lineState}, 32'h3);
        clkEn <= 1'b1;
        cyc(4);
        #1 chk({30'h0, lineState}, {30'h0, v});
        cyc(1);
        bus(1'b1, `REG_STATUS, 32'h30, 32'h0);
        bus(1'b0, `REG_STATUS, 32'h0, 32'h30);
        // Software sleep drops the clock at once
        bus(1'b1, `REG_CTRL, 32'h1, 32'h0);
        cyc(5);
        chk({31'h0, clkUsable}, 32'h0);
        cnt(64, 0);
        bus(1'b0, `REG_CTRL, 32'h1, 32'hFFFFFFFF);
        // Usable but never exact: only the nominal deadline trips
        halfNs <= 8'h55;
        bus(1'b1, `REG_CTRL, 32'h0, 32'h0);
        // Link model chirps first; the bus waits for its chirp to end
        k = 0;
        while (xcvrHs !== 1'b1 || opMode !== 2'h0)
        begin
            k++;
            if (k > 3000)
                give_up();
            cyc(1);
        end
        // Upstream pairs after one stray J, each state outlasting the filter
        for (k = 0; k < 7; k++)
        begin
            linePins <= (k % 2 == 0) ? 2'h2 : 2'h1;
            cyc(3000);
        end
        linePins <= 2'h0; // Upstream ends its chirps with SE0
        chk({30'h0, termHs, xcvrHs}, 32'h3);
        bus(1'b0, `REG_STATUS, 32'h24, 32'h3C);
        bus(1'b0, `REG_GOODCNT, 32'h0, 32'hFFFF);
        suspendN <= 1'b0;
        oscRun <= 1'b0;
        cyc(8);
        chk({31'h0, clkUsable}, 32'h0);
        report_and_stop();
    end
endmodule
